// ### design/uie_top.sv
// usb interrupt, vector and endpoint register block for the microcontroller
`timescale 1ns/1ps

// Operation
// - interrupts are high-then-low pulses
// - resume by control bit 6 or host
// - resume completion pulses the wake line
// - event line gathers twelve endpoints plus five
// - clearing a flag re-pulses next pending source
// - simultaneous sources resolved by fixed priority
// - vector codes for general sources
// - endpoint vector codes from 0x18 upward
// - in buffers mapped at documented windows
// - out buffers mapped at documented windows
// - iso receive data read at port
// - iso transmit data written at port
// - iso receive count high and low
// - iso error register refreshed each frame
// - crc-damaged iso data still delivered
// - zero-length flag for previous frame
// - in done flags, write one clears
// - out done flags, write one clears
// - general event flag bit layout
// - general flags clear on written one
// - endpoint interrupt needs its enable bit; the flag sets without it
// - general enable bits gate sources
module uie_top #(
  parameter int ISO_DEPTH = uie_pkg::ISO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire uie_pkg::uie_bus_type bus,
  output logic [7:0] rdata,
  // usb engine events and iso data
  input wire uie_pkg::uie_usb_type usb,
  // iso transmit byte towards the engine
  output logic iso_tx_valid,
  output logic [7:0] iso_tx_data,
  // buffer window select
  output logic buf_sel,
  output logic buf_is_in,
  output logic [2:0] buf_ep,
  output logic [5:0] buf_ofs,
  // interrupt lines
  output logic wake_pulse_line,
  output logic event_pulse_line,
  output logic suspended
);

  localparam int NUM_SRC = uie_pkg::NUM_GEN + 2 * uie_pkg::NUM_EP;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] ctrl;
    logic [4:0] gen_flags;
    logic [5:0] in_done;
    logic [5:0] out_done;
    logic [4:0] gen_en;
    logic [5:0] in_en;
    logic [5:0] out_en;
    logic [7:0] vector;
    logic susp;
    logic wake;
    uie_pkg::uie_pulse_type pst;
    logic evt;
    logic rearm;
    logic [15:0] rx_cnt;
    logic [15:0] rx_cnt_frame;
    logic crc_frame;
    logic crc_err;
    logic zero_len;
    logic [uie_pkg::ISO_AW-1:0] rd_ptr;
    logic [uie_pkg::ISO_AW-1:0] wr_ptr;
    logic txv;
    logic [7:0] txd;
    logic bsel;
    logic bin;
    logic [2:0] bep;
    logic [5:0] bofs;
  } uie_state_type;

  uie_state_type st_reg;
  uie_state_type st_next;
  uie_pkg::uie_usb_type usb_s1;
  uie_pkg::uie_usb_type usb_s2;
  logic [7:0] iso_mem [ISO_DEPTH];
  logic [NUM_SRC-1:0] pend;
  logic [7:0] win_vec;
  logic any_pend;
  logic clr_hit;
  logic [5:0] in_hit;
  logic [5:0] out_hit;
  logic [15:0] rel_in [uie_pkg::NUM_EP];
  logic [15:0] rel_out [uie_pkg::NUM_EP];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    usb_s1 <= usb;
    usb_s2 <= usb_s1;
  end

  // ----------------------------------------------------------------
  // receive data array; written here, read by the next-state logic at the iso receive port, no reset needed
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (usb_s2.iso_rx_valid) begin
      iso_mem[st_reg.wr_ptr] <= usb_s2.iso_rx_data;
    end
  end

  // ----------------------------------------------------------------
  // buffer window decode
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < uie_pkg::NUM_EP; g++) begin : g_win
      localparam logic [15:0] STEP = 16'(g) * uie_pkg::BUF_STEP;
      assign rel_in[g] = bus.addr - (uie_pkg::IN_BUF_BASE - STEP);
      assign rel_out[g] = bus.addr - (uie_pkg::OUT_BUF_BASE - STEP);
      assign in_hit[g] = rel_in[g] < uie_pkg::BUF_SPAN;
      assign out_hit[g] = rel_out[g] < uie_pkg::BUF_SPAN;
    end
  endgenerate

  // ----------------------------------------------------------------
  // priority: lowest vector code wins
  // ----------------------------------------------------------------
  always_comb begin
    pend = '0;
    pend[uie_pkg::GEN_MSB:0] = st_reg.gen_flags & st_reg.gen_en;
    for (int i = 0; i < uie_pkg::NUM_EP; i++) begin
      pend[uie_pkg::NUM_GEN + 2 * i] = st_reg.in_done[i] & st_reg.in_en[i];
      pend[uie_pkg::NUM_GEN + 2 * i + 1] = st_reg.out_done[i] & st_reg.out_en[i];
    end
    any_pend = |pend;
    win_vec = uie_pkg::VEC_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        if (i < uie_pkg::NUM_GEN) begin
          win_vec = 8'(i) * uie_pkg::VEC_GEN_STEP;
        end else begin
          win_vec = uie_pkg::VEC_EP_BASE + 8'((i - uie_pkg::NUM_GEN) / 2) * uie_pkg::VEC_EP_STEP
                    + (((i - uie_pkg::NUM_GEN) % 2) != 0 ? uie_pkg::VEC_OUT_OFS : 8'h00);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [7:0] wd;
    logic [15:0] a;
    logic resume;
    wr = bus.wr;
    rd = bus.rd;
    wd = bus.wdata;
    a = bus.addr;
    resume = 1'b0;
    st_next = st_reg;
    clr_hit = 1'b0;
    st_next.rdata = 8'h00;
    st_next.txv = 1'b0;
    st_next.wake = 1'b0;
    st_next.evt = 1'b0;
    st_next.bsel = 1'b0;

    // ----------------------------------------------------------------
    // register writes; set beats clear further down
    // ----------------------------------------------------------------
    if (wr) begin
      unique case (a)
        uie_pkg::ADDR_GEN_FLAGS: begin
          st_next.gen_flags = st_reg.gen_flags & ~wd[uie_pkg::GEN_MSB:0];
          clr_hit = |wd[uie_pkg::GEN_MSB:0];
        end
        uie_pkg::ADDR_IN_DONE: begin
          st_next.in_done = st_reg.in_done & ~wd[uie_pkg::EP_MSB:0];
          clr_hit = |wd[uie_pkg::EP_MSB:0];
        end
        uie_pkg::ADDR_OUT_DONE: begin
          st_next.out_done = st_reg.out_done & ~wd[uie_pkg::EP_MSB:0];
          clr_hit = |wd[uie_pkg::EP_MSB:0];
        end
        uie_pkg::ADDR_GEN_ENABLE: begin
          st_next.gen_en = wd[uie_pkg::GEN_MSB:0];
        end
        uie_pkg::ADDR_IN_ENABLE: begin
          st_next.in_en = wd[uie_pkg::EP_MSB:0];
        end
        uie_pkg::ADDR_OUT_ENABLE: begin
          st_next.out_en = wd[uie_pkg::EP_MSB:0];
        end
        uie_pkg::ADDR_CTRL_SFR: begin
          st_next.ctrl = wd;
        end
        uie_pkg::ADDR_ISO_TX_PORT: begin
          st_next.txv = 1'b1;
          st_next.txd = wd;
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // reads, data in the following cycle
    // ----------------------------------------------------------------
    if (rd) begin
      unique case (a)
        uie_pkg::ADDR_GEN_FLAGS: begin
          st_next.rdata = {3'h0, st_reg.gen_flags};
        end
        uie_pkg::ADDR_IN_DONE: begin
          st_next.rdata = {2'h0, st_reg.in_done};
        end
        uie_pkg::ADDR_OUT_DONE: begin
          st_next.rdata = {2'h0, st_reg.out_done};
        end
        uie_pkg::ADDR_GEN_ENABLE: begin
          st_next.rdata = {3'h0, st_reg.gen_en};
        end
        uie_pkg::ADDR_IN_ENABLE: begin
          st_next.rdata = {2'h0, st_reg.in_en};
        end
        uie_pkg::ADDR_OUT_ENABLE: begin
          st_next.rdata = {2'h0, st_reg.out_en};
        end
        uie_pkg::ADDR_CTRL_SFR: begin
          st_next.rdata = st_reg.ctrl;
        end
        uie_pkg::ADDR_VECTOR: begin
          st_next.rdata = st_reg.vector;
        end
        uie_pkg::ADDR_ISO_RX_ERROR: begin
          st_next.rdata = {7'h00, st_reg.crc_err};
        end
        uie_pkg::ADDR_ISO_ZERO_LENGTH: begin
          st_next.rdata = {7'h00, st_reg.zero_len};
        end
        uie_pkg::ADDR_ISO_RX_COUNT_HI: begin
          st_next.rdata = st_reg.rx_cnt_frame[15:8];
        end
        uie_pkg::ADDR_ISO_RX_COUNT_LO: begin
          st_next.rdata = st_reg.rx_cnt_frame[7:0];
        end
        uie_pkg::ADDR_ISO_RX_PORT: begin
          st_next.rdata = iso_mem[st_reg.rd_ptr];
          st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // buffer window access goes out for the ram beside the block
    // ----------------------------------------------------------------
    if ((wr || rd) && (|in_hit || |out_hit)) begin
      st_next.bsel = 1'b1;
      st_next.bin = |in_hit;
      st_next.bep = 3'h0;
      st_next.bofs = 6'h00;
      for (int i = 0; i < uie_pkg::NUM_EP; i++) begin
        if (in_hit[i]) begin
          st_next.bep = 3'(i);
          st_next.bofs = rel_in[i][5:0];
        end
        if (out_hit[i]) begin
          st_next.bep = 3'(i);
          st_next.bofs = rel_out[i][5:0];
        end
      end
    end

    // ----------------------------------------------------------------
    // hardware sets, after clears so that a same-cycle event wins
    // ----------------------------------------------------------------
    st_next.gen_flags = st_next.gen_flags | {usb_s2.bus_reset, usb_s2.suspend, usb_s2.sutok,
                                             usb_s2.sof, usb_s2.sudav};
    st_next.in_done = st_next.in_done | usb_s2.in_ack;
    st_next.out_done = st_next.out_done | usb_s2.out_ok;

    // ----------------------------------------------------------------
    // iso receive bookkeeping per frame
    // ----------------------------------------------------------------
    if (usb_s2.iso_rx_valid) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      st_next.rx_cnt = st_reg.rx_cnt + 16'h0001;
    end
    if (usb_s2.iso_rx_crc_err) begin
      st_next.crc_frame = 1'b1;
    end
    if (usb_s2.sof) begin
      st_next.crc_err = st_reg.crc_frame;
      st_next.zero_len = (st_reg.rx_cnt == 16'h0000);
      st_next.rx_cnt_frame = st_reg.rx_cnt;
      // a byte or error landing with the frame mark belongs to the new frame
      st_next.rx_cnt = usb_s2.iso_rx_valid ? 16'h0001 : 16'h0000;
      st_next.crc_frame = usb_s2.iso_rx_crc_err;
      st_next.rd_ptr = st_reg.wr_ptr - st_reg.rx_cnt[uie_pkg::ISO_AW-1:0];
    end

    // ----------------------------------------------------------------
    // suspend and resume
    // ----------------------------------------------------------------
    if (usb_s2.suspend) begin
      st_next.susp = 1'b1;
    end else if (st_reg.susp && (st_reg.ctrl[uie_pkg::CTRL_WAKE_BIT] || usb_s2.resume_req)) begin
      resume = 1'b1;
    end
    if (resume) begin
      st_next.susp = 1'b0;
      st_next.wake = 1'b1;
      st_next.ctrl[uie_pkg::CTRL_WAKE_BIT] = 1'b0;
    end

    // ----------------------------------------------------------------
    // event pulse; a clear arms another pulse for what is still pending
    // ----------------------------------------------------------------
    st_next.vector = win_vec;
    case (st_reg.pst)
      uie_pkg::PST_IDLE: begin
        if (any_pend && (st_reg.rearm || st_reg.vector != win_vec)) begin
          st_next.evt = 1'b1;
          st_next.rearm = 1'b0;
          st_next.pst = uie_pkg::PST_HIGH;
        end
      end
      uie_pkg::PST_HIGH: st_next.pst = uie_pkg::PST_GAP;
      uie_pkg::PST_GAP: st_next.pst = uie_pkg::PST_IDLE;
      default: st_next.pst = uie_pkg::PST_IDLE;
    endcase
    // set after the pulse logic so a clear beside a pulse is not lost
    if (clr_hit) begin
      st_next.rearm = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.vector <= uie_pkg::VEC_NONE;
      st_reg.pst <= uie_pkg::PST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign iso_tx_valid = st_reg.txv;
  assign iso_tx_data = st_reg.txd;
  assign buf_sel = st_reg.bsel;
  assign buf_is_in = st_reg.bin;
  assign buf_ep = st_reg.bep;
  assign buf_ofs = st_reg.bofs;
  assign wake_pulse_line = st_reg.wake;
  assign event_pulse_line = st_reg.evt;
  assign suspended = st_reg.susp;

endmodule // uie_top

// ### design/uie_pkg.sv
// package for the usb interrupt and endpoint register block
package uie_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_ISO_RX_PORT = 16'hC760;
  localparam logic [15:0] ADDR_ISO_TX_PORT = 16'hC768;
  localparam logic [15:0] ADDR_ISO_RX_COUNT_HI = 16'hC770;
  localparam logic [15:0] ADDR_ISO_RX_COUNT_LO = 16'hC771;
  localparam logic [15:0] ADDR_ISO_RX_ERROR = 16'hC7A0;
  localparam logic [15:0] ADDR_ISO_ZERO_LENGTH = 16'hC7A2;
  localparam logic [15:0] ADDR_IN_DONE = 16'hC7A9;
  localparam logic [15:0] ADDR_OUT_DONE = 16'hC7AA;
  localparam logic [15:0] ADDR_GEN_FLAGS = 16'hC7AB;
  localparam logic [15:0] ADDR_IN_ENABLE = 16'hC7AC;
  localparam logic [15:0] ADDR_OUT_ENABLE = 16'hC7AD;
  localparam logic [15:0] ADDR_GEN_ENABLE = 16'hC7AE;
  localparam logic [15:0] ADDR_VECTOR = 16'hC7A8;
  localparam logic [15:0] ADDR_CTRL_SFR = 16'hC7B0;

  // ----------------------------------------------------------------
  // buffer windows
  // ----------------------------------------------------------------
  localparam logic [15:0] IN_BUF_BASE = 16'hC700;
  localparam logic [15:0] OUT_BUF_BASE = 16'hC6C0;
  localparam logic [15:0] BUF_STEP = 16'h0080;
  localparam logic [15:0] BUF_SPAN = 16'h0040;
  localparam int NUM_EP = 6;

  // ----------------------------------------------------------------
  // field positions and vectors
  // ----------------------------------------------------------------
  localparam int CTRL_WAKE_BIT = 6;
  localparam int NUM_GEN = 5;
  localparam int GEN_MSB = 4;
  localparam int EP_MSB = 5;
  localparam logic [7:0] VEC_GEN_STEP = 8'h04;
  localparam logic [7:0] VEC_EP_BASE = 8'h18;
  localparam logic [7:0] VEC_EP_STEP = 8'h08;
  localparam logic [7:0] VEC_OUT_OFS = 8'h04;
  localparam logic [7:0] VEC_NONE = 8'hFF;
  localparam int ISO_DEPTH = 64;
  localparam int ISO_AW = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uie_bus_type;

  typedef struct packed {
    logic sudav;
    logic sof;
    logic sutok;
    logic suspend;
    logic bus_reset;
    logic resume_req;
    logic [5:0] in_ack;
    logic [5:0] out_ok;
    logic iso_rx_valid;
    logic [7:0] iso_rx_data;
    logic iso_rx_crc_err;
    logic iso_tx_ready;
  } uie_usb_type;

  typedef enum logic [2:0] {
    PST_IDLE = 3'b001,
    PST_HIGH = 3'b010,
    PST_GAP = 3'b100
  } uie_pulse_type;

endpackage

// ### verification/uie_assertions.sv
// checker for the usb interrupt and endpoint register block
`timescale 1ns/1ps
module uie_chk #(
  parameter int ISO_DEPTH = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire uie_pkg::uie_bus_type bus,
  input wire logic [7:0] rdata,
  // usb side
  input wire uie_pkg::uie_usb_type usb,
  input wire logic iso_tx_valid,
  input wire logic [7:0] iso_tx_data,
  // buffer window
  input wire logic buf_sel,
  input wire logic buf_is_in,
  input wire logic [2:0] buf_ep,
  input wire logic [5:0] buf_ofs,
  // interrupt lines
  input wire logic wake_pulse_line,
  input wire logic event_pulse_line,
  input wire logic suspended
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----
  // accesses
  // ----
  sequence s_tx_wr;
    bus.wr && bus.addr == uie_pkg::ADDR_ISO_TX_PORT;
  endsequence
  sequence s_in0_wr;
    bus.wr && bus.addr[15:6] == 10'h31C;
  endsequence
  sequence s_out5_wr;
    bus.wr && bus.addr[15:6] == 10'h311;
  endsequence
  a_event_one_wide: assert property (event_pulse_line |=> !event_pulse_line)
    else $error("event pulse wider than one cycle");
  a_wake_one_wide: assert property (wake_pulse_line |=> !wake_pulse_line)
    else $error("wake pulse wider than one cycle");
  a_wake_ends_suspend: assert property (wake_pulse_line |-> $past(suspended) && !suspended)
    else $error("wake pulse without leaving suspend");
  a_flags_reserved: assert property (bus.rd && bus.addr == uie_pkg::ADDR_GEN_FLAGS |=> rdata[7:5] == 3'h0)
    else $error("event flag upper bits not zero");
  a_done_reserved: assert property (bus.rd && (bus.addr == uie_pkg::ADDR_IN_DONE ||
                                    bus.addr == uie_pkg::ADDR_OUT_DONE) |=> rdata[7:6] == 2'h0)
    else $error("done flag upper bits not zero");
  a_err_reserved: assert property (bus.rd && bus.addr == uie_pkg::ADDR_ISO_RX_ERROR |=> rdata[7:1] == 7'h00)
    else $error("iso error upper bits not zero");
  a_tx_load: assert property (s_tx_wr |=> iso_tx_valid && iso_tx_data == $past(bus.wdata))
    else $error("iso transmit byte not passed on");
  a_tx_cause: assert property (iso_tx_valid |-> $past(bus.wr) && $past(bus.addr) == 16'hC768)
    else $error("iso transmit byte without a write");
  a_in_buf_map: assert property (s_in0_wr |=> buf_sel && buf_is_in && buf_ep == 3'h0 &&
                                 buf_ofs == $past(bus.addr[5:0]))
    else $error("in buffer window decoded wrongly");
  a_out_buf_map: assert property (s_out5_wr |=> buf_sel && !buf_is_in && buf_ep == 3'h5)
    else $error("out buffer window decoded wrongly");
endmodule // uie_chk

bind uie_top uie_chk #(.ISO_DEPTH(ISO_DEPTH)) i_chk (.mclk(mclk), .reset_n(reset_n), .bus(bus),
  .rdata(rdata), .usb(usb), .iso_tx_valid(iso_tx_valid), .iso_tx_data(iso_tx_data), .buf_sel(buf_sel),
  .buf_is_in(buf_is_in), .buf_ep(buf_ep), .buf_ofs(buf_ofs), .wake_pulse_line(wake_pulse_line),
  .event_pulse_line(event_pulse_line), .suspended(suspended));

// ### verification/uie_usb_model.sv
// model of the usb engine that feeds events and iso bytes
`timescale 1ns/1ps
module uie_usb_model (
  // clock
  input wire logic mclk,
  // engine outputs
  output uie_pkg::uie_usb_type usb
);
  logic [7:0] last_q;
  initial begin
    usb = '0;
    last_q = 8'h00;
  end
  // one-cycle strobe; idle data shows the inverse so stale bytes never match
  task automatic ev(input uie_pkg::uie_usb_type m);
    if (!m.iso_rx_valid) m.iso_rx_data = ~last_q;
    usb <= m;
    @(posedge mclk);
    m = '0;
    m.iso_rx_data = ~last_q;
    usb <= m;
    @(posedge mclk);
  endtask
  task automatic rx(input logic [7:0] d, input logic e);
    uie_pkg::uie_usb_type m;
    m = '0;
    m.iso_rx_valid = 1'b1;
    m.iso_rx_data = d;
    m.iso_rx_crc_err = e;
    last_q = d;
    ev(m);
  endtask
endmodule // uie_usb_model

// ### verification/testbench.sv
// self-checking testbench for the usb interrupt and endpoint register block
`timescale 1ns/1ps
module testbench;
  logic mclk;
  logic reset_n;
  uie_pkg::uie_bus_type bus;
  uie_pkg::uie_usb_type usb;
  uie_pkg::uie_usb_type m;
  logic [7:0] rdata;
  logic wake_pulse_line;
  logic event_pulse_line;
  logic suspended;
  logic iso_tx_valid;
  logic [7:0] iso_tx_data;
  logic buf_sel;
  logic buf_is_in;
  logic [2:0] buf_ep;
  logic [5:0] buf_ofs;
  int tx_n = 0;
  int bs_n = 0;
  int failures = 0;
  int checks_done = 0;
  int ev_n = 0;
  int wk_n = 0;
  int n;
  logic [15:0] adr [7] = '{16'hC7AB, 16'hC7AB, 16'hC7AB, 16'hC7AB, 16'hC7AB, 16'hC7A9, 16'hC7AA};
  logic [7:0] msk [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h01, 8'h20};
  logic [7:0] vec [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h44};
  uie_top #(.ISO_DEPTH(64)) i_dut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .usb(usb),
    .iso_tx_valid(iso_tx_valid), .iso_tx_data(iso_tx_data), .buf_sel(buf_sel), .buf_is_in(buf_is_in),
    .buf_ep(buf_ep), .buf_ofs(buf_ofs),
    .wake_pulse_line(wake_pulse_line), .event_pulse_line(event_pulse_line), .suspended(suspended));
  uie_usb_model i_usb (.mclk(mclk), .usb(usb));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (event_pulse_line === 1'b1) ev_n++;
    if (wake_pulse_line === 1'b1) wk_n++;
    if (iso_tx_valid === 1'b1) tx_n++;
    if (buf_sel === 1'b1) bs_n++;
  end
  // ----
  // access and compare
  // ----
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= {a, d, 2'b10};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus <= {a, 8'h00, 2'b01};
    @(posedge mclk);
    bus <= '0;
    #1 chk($sformatf("read %h", a), rdata, e);
    @(posedge mclk);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    results();
  end
  // ----
  // tests
  // ----
  initial begin
    reset_n = 1'b0;
    bus = '0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(16'hC7A8, 8'hFF);
    rd(16'hC7AB, 8'h00);
    wr(16'hC7F0, 8'h5A);
    rd(16'hC7F0, 8'h00);
    $display("test registers done");
    wr(16'hC7AE, 8'h1F);
    wr(16'hC7AC, 8'h3F);
    wr(16'hC7AD, 8'h3F);
    n = ev_n;
    m = '0;
    {m.sudav, m.sof, m.sutok, m.suspend, m.bus_reset} = 5'h1F;
    m.in_ack = 6'h01;
    m.out_ok = 6'h20;
    i_usb.ev(m);
    repeat (6) @(posedge mclk);
    chk("first pulse", 8'(ev_n - n), 8'h01);
    rd(16'hC7AB, 8'h1F);
    wr(16'hC7AB, 8'h00);
    rd(16'hC7AB, 8'h1F);
    rd(16'hC7A9, 8'h01);
    rd(16'hC7AA, 8'h20);
    // firmware side: the main flag is taken by counting pulses after each clear
    for (int i = 0; i < 7; i++) begin
      n = ev_n;
      rd(16'hC7A8, vec[i]);
      wr(adr[i], msk[i]);
      repeat (4) @(posedge mclk);
      chk("next pulse", 8'(ev_n - n), (i < 6) ? 8'h01 : 8'h00);
    end
    rd(16'hC7A8, 8'hFF);
    $display("test priority done");
    wr(16'hC7AC, 8'h00);
    n = ev_n;
    m = '0;
    m.in_ack = 6'h04;
    i_usb.ev(m);
    repeat (6) @(posedge mclk);
    chk("masked", 8'(ev_n - n), 8'h00);
    rd(16'hC7A9, 8'h04);
    wr(16'hC7AC, 8'h04);
    repeat (4) @(posedge mclk);
    chk("unmasked", 8'(ev_n - n), 8'h01);
    rd(16'hC7A8, 8'h28);
    wr(16'hC7A9, 8'h04);
    rd(16'hC7A9, 8'h00);
    $display("test enables done");
    for (int k = 0; k < 2; k++) begin
      m = '0;
      m.suspend = 1'b1;
      i_usb.ev(m);
      repeat (6) @(posedge mclk);
      chk("suspended", {7'h00, suspended}, 8'h01);
      wr(16'hC7AB, 8'h08);
      n = wk_n;
      m = '0;
      m.resume_req = 1'b1;
      if (k == 0) wr(16'hC7B0, 8'h40);
      else i_usb.ev(m);
      repeat (6) @(posedge mclk);
      chk("wake", 8'(wk_n - n), 8'h01);
      chk("awake", {7'h00, suspended}, 8'h00);
    end
    $display("test wake done");
    i_usb.rx(8'h11, 1'b0);
    i_usb.rx(8'h22, 1'b1);
    i_usb.rx(8'h33, 1'b0);
    m = '0;
    m.sof = 1'b1;
    i_usb.ev(m);
    repeat (6) @(posedge mclk);
    rd(16'hC770, 8'h00);
    rd(16'hC771, 8'h03);
    rd(16'hC7A0, 8'h01);
    rd(16'hC7A2, 8'h00);
    rd(16'hC760, 8'h11);
    rd(16'hC760, 8'h22);
    rd(16'hC760, 8'h33);
    wr(16'hC7AB, 8'h02);
    n = tx_n;
    wr(16'hC768, 8'hA5);
    chk("tx byte", iso_tx_data, 8'hA5);
    @(posedge mclk);
    chk("tx pulses", 8'(tx_n - n), 8'h01);
    n = bs_n;
    wr(16'hC705, 8'h3C);
    chk("in window ep", {4'h0, buf_is_in, buf_ep}, 8'h08);
    chk("in window ofs", {2'h0, buf_ofs}, 8'h05);
    wr(16'hC445, 8'hC3);
    chk("out window ep", {4'h0, buf_is_in, buf_ep}, 8'h05);
    chk("out window ofs", {2'h0, buf_ofs}, 8'h05);
    @(posedge mclk);
    chk("window pulses", 8'(bs_n - n), 8'h02);
    wr(16'hC7AE, 8'h1D);
    n = ev_n;
    m = '0;
    m.sof = 1'b1;
    i_usb.ev(m);
    repeat (6) @(posedge mclk);
    chk("sof masked", 8'(ev_n - n), 8'h00);
    rd(16'hC7A2, 8'h01);
    rd(16'hC7A0, 8'h00);
    rd(16'hC771, 8'h00);
    $display("test iso done");
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(16'hC7AB, 8'h00);
    rd(16'hC7A8, 8'hFF);
    $display("test reset done");
    results();
  end
endmodule // testbench
